/* File: common/boot_strap_pkg.sv */
package boot_strap_pkg;

   // ----------------------------------------------------------------
   // Strap field layout
   // ----------------------------------------------------------------
   localparam int STRAP_W = 16;
   localparam int FREQ_HI = 15;
   localparam int FREQ_LO = 14;
   localparam int RSV_HI = 13;
   localparam int RSV_LO = 12;
   localparam int AUX_BIT = 5;
   localparam int MODE_HI = 4;
   localparam int MODE_LO = 0;

   // Only this value of the reserved field is legal from the board.
   localparam logic [1:0] RSV_OK = 2'h0;

   // Boot source field codes.
   localparam logic [4:0] MODE_CARD = 5'h1c;
   localparam logic [4:0] MODE_SPI = 5'h18;

   // Crystal frequency codes and their values in kHz.
   localparam logic [1:0] FREQ_19M2 = 2'h0;
   localparam logic [1:0] FREQ_24M = 2'h1;
   localparam logic [1:0] FREQ_25M = 2'h2;
   localparam logic [1:0] FREQ_26M = 2'h3;
   localparam logic [15:0] KHZ_19M2 = 16'h4b00;
   localparam logic [15:0] KHZ_24M = 16'h5dc0;
   localparam logic [15:0] KHZ_25M = 16'h61a8;
   localparam logic [15:0] KHZ_26M = 16'h6590;

   // Cycles after reset release before the synchronised pins are trusted.
   localparam logic [1:0] SETTLE_CYC = 2'h2;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] OFS_STRAP = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_SEQ = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam int CTRL_FOUND_BIT = 0;
   localparam int CTRL_ABSENT_BIT = 1;
   localparam int CTRL_RESTART_BIT = 2;
   localparam int CFG_FREQ_LO = 0;
   localparam int CFG_AUX_BIT = 2;
   localparam int CFG_RSV_BAD_BIT = 3;
   localparam int CFG_MODE_OK_BIT = 4;
   localparam int CFG_KHZ_LO = 16;
   localparam int SEQ_SRC_LO = 0;
   localparam int SEQ_IDX_LO = 4;
   localparam int SEQ_STATE_LO = 8;

   // ----------------------------------------------------------------
   // Boot sources and sequencer states
   // ----------------------------------------------------------------
   localparam int LIST_LEN = 4;
   typedef logic [1:0] idx_t;
   localparam idx_t IDX_LAST = 2'h3;

   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_ONBOARD_CARD = 3'b001,
      SRC_REMOVABLE_CARD = 3'b010,
      SRC_FIRST_SERIAL = 3'b011,
      SRC_FIRST_USB = 3'b100,
      SRC_FIRST_SPI = 3'b101
   } src_e;

   typedef enum logic [1:0] {
      SEQ_WAIT = 2'b00,
      SEQ_TRY = 2'b01,
      SEQ_DONE = 2'b10,
      SEQ_EXHAUSTED = 2'b11
   } seq_e;

endpackage : boot_strap_pkg

/* File: common/strap_if.sv */
`timescale 1ns/100ps
// Carries the latched strap word from the capture stage to the decoder.
interface strap_if;
   logic [15:0] straps;
   logic valid;
   modport capture (output straps, output valid);
   modport decode (input straps, input valid);
endinterface : strap_if

/* File: hdl/strap_capture.sv */
`timescale 1ns/100ps
module strap_capture (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [boot_strap_pkg::STRAP_W-1:0] pins,
   strap_if.capture cap
);
   import boot_strap_pkg::*;

   typedef struct packed {
      logic [STRAP_W-1:0] sync1;
      logic [STRAP_W-1:0] sync2;
      logic [1:0] settle;
      logic [STRAP_W-1:0] straps;
      logic valid;
   } cap_s;

   cap_s state_r;
   cap_s state_nxt;

   // ----------------------------------------------------------------
   // Synchronise the pins and latch them once after reset
   // ----------------------------------------------------------------
   // The first stage feeds only the second; the latch waits until the
   // chain holds pin levels sampled after reset, then freezes for good.
   always_comb begin
      state_nxt = state_r;
      state_nxt.sync1 = pins;
      state_nxt.sync2 = state_r.sync1;
      if (!state_r.valid) begin
         if (state_r.settle == SETTLE_CYC) begin
            state_nxt.straps = state_r.sync2;
            state_nxt.valid = 1'b1;
         end else begin
            state_nxt.settle = state_r.settle + 2'h1;
         end
      end
   end

   // Register the state; reset loads constants only.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign cap.straps = state_r.straps;
   assign cap.valid = state_r.valid;

endmodule : strap_capture

/* File: hdl/boot_strap_decoder.sv */
`timescale 1ns/100ps
module boot_strap_decoder (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [boot_strap_pkg::STRAP_W-1:0] boot_strap_pins,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [boot_strap_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [1:0] crystal_freq_code,
   output logic aux_clock_output,
   output logic straps_valid,
   output logic [2:0] boot_source,
   output logic boot_try,
   output logic boot_found,
   output logic boot_exhausted
);
   import boot_strap_pkg::*;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------

   // Source at a given position of the list chosen by the mode field.
   // An unknown mode field gives no source at any position.
   function automatic src_e src_at(input logic [4:0] mode, input idx_t idx);
      src_e s;
      s = SRC_NONE;
      if (mode == MODE_CARD) begin
         unique case (idx)
            2'h0: s = SRC_ONBOARD_CARD;
            2'h1: s = SRC_REMOVABLE_CARD;
            2'h2: s = SRC_FIRST_SERIAL;
            2'h3: s = SRC_FIRST_USB;
         endcase
      end else if (mode == MODE_SPI) begin
         unique case (idx)
            2'h0: s = SRC_FIRST_SPI;
            2'h1: s = SRC_REMOVABLE_CARD;
            2'h2: s = SRC_FIRST_USB;
            2'h3: s = SRC_FIRST_SERIAL;
         endcase
      end
      return s;
   endfunction : src_at

   // Crystal frequency in kHz for a frequency code.
   function automatic logic [15:0] khz_of(input logic [1:0] code);
      logic [15:0] k;
      k = KHZ_19M2;
      unique case (code)
         FREQ_19M2: k = KHZ_19M2;
         FREQ_24M: k = KHZ_24M;
         FREQ_25M: k = KHZ_25M;
         FREQ_26M: k = KHZ_26M;
      endcase
      return k;
   endfunction : khz_of

   // True for a mode field that names a known boot list.
   // Any other code sends the sequencer straight to the exhausted state.
   function automatic logic mode_known(input logic [4:0] mode);
      return (mode == MODE_CARD) || (mode == MODE_SPI);
   endfunction : mode_known

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // The capture stage owns the pin synchroniser; no logic here reads the
   // pins directly, so pin activity after the latch cannot reach the decoder.
   strap_if cap_bus ();

   strap_capture u_capture (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .pins(boot_strap_pins),
      .cap(cap_bus.capture)
   );

   // ----------------------------------------------------------------
   // State of the decoder
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [1:0] freq;
      logic aux_en;
      logic aux_clk;
      logic rsv_bad;
      logic [4:0] mode;
      seq_e seq;
      idx_t idx;
      src_e src;
      logic [31:0] rdata;
      logic ack;
      // Status flags mirror the sequencer state so each output leaves a flip-flop.
      logic trying;
      logic found;
      logic exhausted;
   } dec_s;

   dec_s state_r;
   dec_s state_nxt;

   // Strap fields as they arrive from the capture stage.
   logic [STRAP_W-1:0] straps;
   logic [4:0] mode_in;
   assign straps = cap_bus.straps;
   assign mode_in = straps[MODE_HI:MODE_LO];

   // ----------------------------------------------------------------
   // Bus request decoding
   // ----------------------------------------------------------------
   // A request counts once: while ack is high the same strobe is not taken
   // again, so a master that holds stb gets one answer per request.
   // Only byte lane 0 gates a command write; the other lanes carry no command.
   logic req;
   logic wr_ctrl;
   logic hit;
   logic cmd_found;
   logic cmd_absent;
   logic cmd_restart;
   assign req = wb_cyc_i && wb_stb_i && !state_r.ack;
   assign hit = (wb_adr_i[ADR_W-1:4] == 4'h0);
   assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_CTRL);
   assign cmd_found = wr_ctrl && wb_dat_i[CTRL_FOUND_BIT];
   assign cmd_absent = wr_ctrl && wb_dat_i[CTRL_ABSENT_BIT];
   assign cmd_restart = wr_ctrl && wb_dat_i[CTRL_RESTART_BIT];

   // ----------------------------------------------------------------
   // Register read values
   // ----------------------------------------------------------------
   // Each value is built from the current state, so a read shows what the
   // outputs show in the same cycle; the strap word reads zero until latched.
   logic [31:0] rd_strap;
   logic [31:0] rd_config;
   logic [31:0] rd_seq;
   always_comb begin
      rd_strap = {16'h0000, straps};
      rd_config = 32'h0000_0000;
      rd_config[CFG_FREQ_LO +: 2] = state_r.freq;
      rd_config[CFG_AUX_BIT] = state_r.aux_en;
      rd_config[CFG_RSV_BAD_BIT] = state_r.rsv_bad;
      rd_config[CFG_MODE_OK_BIT] = mode_known(state_r.mode);
      rd_config[CFG_KHZ_LO +: 16] = khz_of(state_r.freq);
      rd_seq = 32'h0000_0000;
      rd_seq[SEQ_SRC_LO +: 3] = state_r.src;
      rd_seq[SEQ_IDX_LO +: 2] = state_r.idx;
      rd_seq[SEQ_STATE_LO +: 2] = state_r.seq;
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------

   // Takes the decoded fields once, steps through the boot list on the
   // results reported over the bus, and answers bus cycles.
   always_comb begin
      state_nxt = state_r;

      // Fields are taken once when the capture stage marks the straps
      // valid; the capture never re-arms before the next reset.
      if (cap_bus.valid && !state_r.valid) begin
         state_nxt.valid = 1'b1;
         state_nxt.freq = straps[FREQ_HI:FREQ_LO];
         state_nxt.aux_en = straps[AUX_BIT];
         // A nonzero reserved field is only flagged for software; the boot
         // order never depends on it.
         state_nxt.rsv_bad = (straps[RSV_HI:RSV_LO] != RSV_OK);
         // Bits 11:6 take no part in any decision below.
         state_nxt.mode = mode_in;
      end

      // The auxiliary clock toggles at half the core rate while enabled
      // and rests low otherwise. The enable is a latched strap, so the output
      // neither starts nor stops until the next reset.
      if (state_r.aux_en) begin
         state_nxt.aux_clk = !state_r.aux_clk;
      end else begin
         state_nxt.aux_clk = 1'b0;
      end

      // Boot source sequencer.
      unique case (state_r.seq)
         SEQ_WAIT: begin
            // Every walk, the first and each one after a restart, starts at
            // the head of the list.
            if (state_r.valid) begin
               state_nxt.idx = 2'h0;
               if (mode_known(state_r.mode)) begin
                  state_nxt.seq = SEQ_TRY;
                  state_nxt.src = src_at(state_r.mode, 2'h0);
               end else begin
                  // No known order: nothing can be tried.
                  state_nxt.seq = SEQ_EXHAUSTED;
                  state_nxt.src = SRC_NONE;
               end
            end
         end
         SEQ_TRY: begin
            if (cmd_found) begin
               state_nxt.seq = SEQ_DONE;
            end else if (cmd_absent) begin
               // An empty source hands over to the next in the list.
               if (state_r.idx == IDX_LAST) begin
                  state_nxt.seq = SEQ_EXHAUSTED;
                  state_nxt.src = SRC_NONE;
               end else begin
                  state_nxt.idx = state_r.idx + 2'h1;
                  state_nxt.src = src_at(state_r.mode, state_r.idx + 2'h1);
               end
            end
         end
         SEQ_DONE, SEQ_EXHAUSTED: begin
            // A restart walks the same latched order again from the top.
            if (cmd_restart) begin
               state_nxt.seq = SEQ_WAIT;
               state_nxt.src = SRC_NONE;
               state_nxt.idx = 2'h0;
            end
         end
      endcase

      // Status flags follow the next sequencer state, so they change at the
      // same edge as the source.
      state_nxt.trying = (state_nxt.seq == SEQ_TRY);
      state_nxt.found = (state_nxt.seq == SEQ_DONE);
      state_nxt.exhausted = (state_nxt.seq == SEQ_EXHAUSTED);

      // Bus slave: answer one cycle after the strobe, then drop ack.
      // Writes to read-only or unmapped addresses are acknowledged and change
      // nothing; there is no error answer.
      state_nxt.ack = req;
      state_nxt.rdata = 32'h0000_0000;
      if (req && !wb_we_i && hit) begin
         unique case (wb_adr_i[3:0])
            OFS_STRAP[3:0]: state_nxt.rdata = rd_strap;
            OFS_CONFIG[3:0]: state_nxt.rdata = rd_config;
            OFS_SEQ[3:0]: state_nxt.rdata = rd_seq;
            default: state_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Reset returns every field to a constant.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= '{
            valid: 1'b0,
            freq: FREQ_19M2,
            aux_en: 1'b0,
            aux_clk: 1'b0,
            rsv_bad: 1'b0,
            mode: 5'h00,
            seq: SEQ_WAIT,
            idx: 2'h0,
            src: SRC_NONE,
            rdata: 32'h0000_0000,
            ack: 1'b0,
            trying: 1'b0,
            found: 1'b0,
            exhausted: 1'b0
         };
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each taken from the state register
   // ----------------------------------------------------------------

   // Bus answer.
   assign wb_dat_o = state_r.rdata;
   assign wb_ack_o = state_r.ack;

   // Decoded strap results.
   assign crystal_freq_code = state_r.freq;
   assign aux_clock_output = state_r.aux_clk;
   assign straps_valid = state_r.valid;

   // Sequencer view.
   assign boot_source = state_r.src;
   assign boot_try = state_r.trying;
   assign boot_found = state_r.found;
   assign boot_exhausted = state_r.exhausted;

endmodule : boot_strap_decoder

/* File: test/strap_board.sv */
`timescale 1ns/100ps
// Board side of the straps: pull resistors set a word, the button grounds one bit.
module strap_board (
   input wire logic [15:0] pulls,
   input wire logic button,
   output logic [15:0] pins
);
   // The reserved pair is tied low, and the held button beats the bit 2 pull-up.
   always_comb begin
      pins = pulls;
      pins[13:12] = 2'h0;
      if (button) begin
         pins[2] = 1'h0;
      end
   end
endmodule : strap_board

/* File: test/boot_strap_decoder_monitor.sv */
`timescale 1ns/100ps
module boot_strap_decoder_monitor (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [15:0] boot_strap_pins,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] crystal_freq_code,
   input wire logic aux_clock_output,
   input wire logic straps_valid,
   input wire logic [2:0] boot_source,
   input wire logic boot_try,
   input wire logic boot_found,
   input wire logic boot_exhausted
);
   import boot_strap_pkg::*;
   logic sv_r;
   logic [15:0] lat_r;
   logic req;
   logic ctl;
   // Keeps the pins as they stood when the decoder declared them latched.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sv_r <= 1'h0;
         lat_r <= 16'h0000;
      end else begin
         sv_r <= straps_valid;
         if (straps_valid && !sv_r) begin
            lat_r <= boot_strap_pins;
         end
      end
   end
   // A fresh bus request, and a command write made while a source is tried.
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign ctl = req && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0] && boot_try;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   a_ack_answer: assert property (req |=> wb_ack_o) else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_freq_code: assert property (
      sv_r |-> crystal_freq_code == lat_r[15:14]) else $error("freq code wrong");
   a_aux_clock: assert property (
      sv_r |=> aux_clock_output == (lat_r[5] && !$past(aux_clock_output)))
      else $error("aux clock wrong");
   a_first_card: assert property (
      $rose(straps_valid) && boot_strap_pins[4:0] == MODE_CARD
      |=> boot_try && boot_source == SRC_ONBOARD_CARD) else $error("card order wrong");
   a_first_spi: assert property (
      $rose(straps_valid) && boot_strap_pins[4:0] == MODE_SPI
      |=> boot_try && boot_source == SRC_FIRST_SPI) else $error("spi order wrong");
   a_absent_step: assert property (
      ctl && wb_dat_i[1:0] == 2'h2 |=> boot_source != $past(boot_source))
      else $error("no step on absent");
   a_found_stop: assert property (
      ctl && wb_dat_i[0] |=> boot_found && !boot_try) else $error("found ignored");
   c_exhausted: cover property ($rose(boot_exhausted));
   c_found: cover property ($rose(boot_found));
   c_aux_on: cover property (sv_r && lat_r[5]);
endmodule : boot_strap_decoder_monitor

/* File: test/boot_strap_decoder_tb.sv */
`timescale 1ns/100ps
module boot_strap_decoder_tb;
   import boot_strap_pkg::*;
   typedef struct packed {
      logic [15:0] w;
      logic b;
      logic [11:0] lst;
   } row_s;
   // Strap word, button, then the four sources expected in order.
   localparam row_s ROWS [6] = '{
      '{16'h001c, 1'h0, 12'h29c}, '{16'h403c, 1'h0, 12'h29c},
      '{16'h801c, 1'h1, 12'haa3}, '{16'hcfd8, 1'h0, 12'haa3},
      '{16'h0fdc, 1'h0, 12'h29c}, '{16'h0010, 1'h0, 12'h000}};
   logic mclk = 1'h0, sys_rst = 1'h1, button = 1'h0;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [15:0] pulls = 16'h0000, boot_strap_pins;
   logic [1:0] crystal_freq_code;
   logic [2:0] boot_source;
   logic wb_ack_o, aux_clock_output, straps_valid, boot_try, boot_found, boot_exhausted;
   logic a1;
   logic [31:0] cfg;
   logic [31:0] sq;
   localparam logic [15:0] KHZ_TAB [4] = '{KHZ_19M2, KHZ_24M, KHZ_25M, KHZ_26M};
   int errors = 0, total_checks = 0;

   always #20 mclk = ~mclk;

   strap_board u_strap_board (.pulls, .button, .pins(boot_strap_pins));
   boot_strap_decoder u_boot_strap_decoder (.mclk, .sys_rst, .boot_strap_pins,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .crystal_freq_code, .aux_clock_output, .straps_valid, .boot_source,
      .boot_try, .boot_found, .boot_exhausted);

   // ---------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------
   // Compares one value and reports a mismatch at once.
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One classic bus cycle, held until ack is sampled high.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      // Only the watchdog ends a wait for an answer that never comes.
      do begin
         @(posedge mclk);
      end while (wb_ack_o !== 1'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : wb

   // Sets the board, holds reset ten cycles, then lets the straps latch.
   task boot(input row_s r);
      pulls <= r.w;
      button <= r.b;
      sys_rst <= 1'h1;
      repeat (10) @(posedge mclk);
      chk("reset", 0, {boot_source, straps_valid, boot_try});
      sys_rst <= 1'h0;
      repeat (8) @(posedge mclk);
   endtask : boot

   task test_done;
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // ---------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------
   // Table rows walk each boot order to its end, then the awkward cases.
   initial begin
      for (int i = 0; i < 6; i++) begin
         boot(ROWS[i]);
         chk("freq", ROWS[i].w[15:14], crystal_freq_code);
         chk("valid", 1, straps_valid);
         a1 = aux_clock_output;
         @(posedge mclk);
         chk("aux", {2{ROWS[i].w[5]}}, {a1 ^ aux_clock_output, a1 | aux_clock_output});
         for (int k = 0; k < LIST_LEN; k++) begin
            chk("source", ROWS[i].lst[11-3*k -: 3], boot_source);
            chk("try", ROWS[i].lst != 12'h000, boot_try);
            wb(1'h1, OFS_CTRL, 32'h2, 4'hf);
         end
         chk("exhausted", 1, boot_exhausted);
         // Crystal kHz, mode known, reserved flag, aux enable and freq code.
         cfg = {KHZ_TAB[ROWS[i].w[15:14]], 11'h000, ROWS[i].lst != 12'h000, 1'h0,
                ROWS[i].w[5], ROWS[i].w[15:14]};
         wb(1'h0, OFS_CONFIG, 32'h0, 4'hf);
         chk("config", cfg, rd);
         // An ended walk shows state 3 and, for a known list, the last index.
         sq = {22'h000000, 2'h3, 2'h0, (ROWS[i].lst != 12'h000) ? 2'h3 : 2'h0, 4'h0};
         wb(1'h0, OFS_SEQ, 32'h0, 4'hf);
         chk("seq", sq, rd);
      end
      boot(ROWS[0]);
      pulls <= 16'hffff;
      button <= 1'h1;
      wb(1'h1, OFS_CTRL, 32'h2, 4'he);
      chk("hold_src", 1, boot_source);
      chk("hold_freq", 0, crystal_freq_code);
      wb(1'h0, OFS_STRAP, 32'h0, 4'hf);
      chk("strap_rd", 32'h001c, rd);
      wb(1'h0, 8'h40, 32'h0, 4'hf);
      chk("unmapped", 0, rd);
      wb(1'h1, OFS_CTRL, 32'h3, 4'h1);
      chk("found", 2'h2, {boot_found, boot_try});
      wb(1'h1, OFS_CTRL, 32'h4, 4'h1);
      @(posedge mclk);
      chk("restart", 4'h3, {boot_source, boot_try});
      test_done;
   end

   // Cuts a hang short well beyond the length of the sequence.
   initial begin
      repeat (3000) @(posedge mclk);
      errors++;
      test_done;
   end
endmodule : boot_strap_decoder_tb

bind boot_strap_decoder boot_strap_decoder_monitor u_boot_strap_decoder_monitor (.mclk,
   .sys_rst, .boot_strap_pins, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_ack_o, .crystal_freq_code, .aux_clock_output, .straps_valid,
   .boot_source, .boot_try, .boot_found, .boot_exhausted);
